// ==== rtl/tcsl_loader.sv ====
// serial receiver that latches an 8-bit tuning control word
`timescale 1ns/100ps
module tcsl_loader
  import tcsl_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     rst_b,
  input  wire logic     serial_select,
  input  wire logic     shift_clk,
  input  wire logic     shift_data_pin,
  output tcsl_tune_type tuning_state,
  output logic          standby_request,
  output logic          device_active,
  output logic [5:0]    cap_setting,
  output logic          word_applied
);
  logic          sel_lvl;
  logic          sel_rise;
  logic          sel_fall;
  logic          sclk_lvl;
  logic          sclk_rise;
  logic          dat_lvl;
  tcsl_word_type shift_q;
  tcsl_word_type active_q;
  logic          applied_q;
  logic          dev_act_q;
  logic [5:0]    cap_q;

  function automatic logic [5:0] tcsl_cap_index(input tcsl_tune_type st);
    tcsl_cap_index = 6'({1'b0, st} * CAP_STEPS_PER_STATE);
  endfunction : tcsl_cap_index

  tcsl_sync u_sel (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pin_in  (serial_select),
    .level_q (sel_lvl),
    .rise    (sel_rise),
    .fall    (sel_fall)
  );

  tcsl_sync u_sclk (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pin_in  (shift_clk),
    .level_q (sclk_lvl),
    .rise    (sclk_rise),
    .fall    ()
  );

  // data is sampled through the same depth so it aligns with the clock edge
  tcsl_sync u_dat (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pin_in  (shift_data_pin),
    .level_q (dat_lvl),
    .rise    (),
    .fall    ()
  );

  // plain shift register, no counter: excess leading bits fall off the top
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= WORD_RESET;
    end else if (sel_lvl && sclk_rise) begin
      shift_q <= {shift_q[WORD_W-2:0], dat_lvl};
    end
  end

  // active latch only moves on select fall; bits 7,6 kept as written
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      active_q <= WORD_RESET;
    end else if (sel_fall) begin
      active_q <= shift_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      applied_q <= 1'b0;
    end else begin
      applied_q <= sel_fall;
    end
  end

  // decoded outputs load with the latch, so no field moves on its own edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dev_act_q <= !WORD_RESET[STBY_BIT];
      cap_q     <= {1'b0, WORD_RESET[TUNE_MSB:TUNE_LSB]};
    end else if (sel_fall) begin
      dev_act_q <= !shift_q[STBY_BIT];
      cap_q     <= tcsl_cap_index(shift_q[TUNE_MSB:TUNE_LSB]);
    end
  end

  assign tuning_state    = active_q[TUNE_MSB:TUNE_LSB];
  assign standby_request = active_q[STBY_BIT];
  assign device_active   = dev_act_q;
  assign cap_setting     = cap_q;
  assign word_applied    = applied_q;

  sequence s_sel_fall;
    sel_fall;
  endsequence

  property p_latch_on_fall;
    @(posedge clk_sys) disable iff (!rst_b)
      s_sel_fall |=> (active_q == $past(shift_q));
  endproperty
  a_latch_on_fall: assert property (p_latch_on_fall)
    else $error("active word not loaded on select fall");

  property p_hold_no_fall;
    @(posedge clk_sys) disable iff (!rst_b)
      !sel_fall |=> $stable(active_q);
  endproperty
  a_hold_no_fall: assert property (p_hold_no_fall)
    else $error("active word changed without select fall");

  property p_shift_msb_first;
    @(posedge clk_sys) disable iff (!rst_b)
      (sel_lvl && sclk_rise) |=>
        (shift_q == {$past(shift_q[WORD_W-2:0]), $past(dat_lvl)});
  endproperty
  a_shift_msb_first: assert property (p_shift_msb_first)
    else $error("shift register did not take bit at low end");

  property p_ignore_unselected;
    @(posedge clk_sys) disable iff (!rst_b)
      !sel_lvl |=> $stable(shift_q);
  endproperty
  a_ignore_unselected: assert property (p_ignore_unselected)
    else $error("shift register moved while not selected");

  property p_keep_last_eight;
    @(posedge clk_sys) disable iff (!rst_b)
      (sel_lvl && sclk_rise) |=>
        (shift_q[WORD_W-1:1] == $past(shift_q[WORD_W-2:0]));
  endproperty
  a_keep_last_eight: assert property (p_keep_last_eight)
    else $error("shift register lost its window");

  property p_standby_map;
    @(posedge clk_sys) disable iff (!rst_b)
      s_sel_fall |=> (standby_request == $past(shift_q[STBY_BIT]))
        && (device_active != standby_request);
  endproperty
  a_standby_map: assert property (p_standby_map)
    else $error("standby bit not mapped from bit 5");

  property p_tune_map;
    @(posedge clk_sys) disable iff (!rst_b)
      s_sel_fall |=> (tuning_state == $past(shift_q[TUNE_MSB:TUNE_LSB]))
        && (cap_setting == {1'b0, tuning_state});
  endproperty
  a_tune_map: assert property (p_tune_map)
    else $error("tuning state or capacitance index wrong");

  property p_applied_pulse;
    @(posedge clk_sys) disable iff (!rst_b)
      s_sel_fall |=> word_applied ##1 !word_applied;
  endproperty
  a_applied_pulse: assert property (p_applied_pulse)
    else $error("applied pulse not one cycle after select fall");

  property p_no_shift_on_idle_clk;
    @(posedge clk_sys) disable iff (!rst_b)
      (sel_lvl && !sclk_rise) |=> $stable(shift_q);
  endproperty
  a_no_shift_on_idle_clk: assert property (p_no_shift_on_idle_clk)
    else $error("shift without rising shift clock");

  // three samples each side are what the agreement stages need
  sequence s_pin_held_high;
    serial_select [*3];
  endsequence

  sequence s_pin_dropped;
    !serial_select [*3];
  endsequence

  property p_pin_fall_applies;
    @(posedge clk_sys) disable iff (!rst_b)
      s_pin_held_high ##1 s_pin_dropped |=> sel_fall ##1 word_applied;
  endproperty
  a_pin_fall_applies: assert property (p_pin_fall_applies)
    else $error("select pin fall did not apply the word in time");

  sequence s_sclk_low;
    !shift_clk [*3];
  endsequence

  sequence s_sclk_high;
    shift_clk [*3];
  endsequence

  property p_sclk_rise_found;
    @(posedge clk_sys) disable iff (!rst_b)
      s_sclk_low ##1 s_sclk_high |=> sclk_rise;
  endproperty
  a_sclk_rise_found: assert property (p_sclk_rise_found)
    else $error("shift clock rise not found after the stages");

  property p_outputs_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      !sel_fall |=> $stable({standby_request, device_active, tuning_state,
                             cap_setting});
  endproperty
  a_outputs_hold: assert property (p_outputs_hold)
    else $error("applied outputs moved without select fall");

  property p_active_inverse;
    @(posedge clk_sys) disable iff (!rst_b)
      device_active != standby_request;
  endproperty
  a_active_inverse: assert property (p_active_inverse)
    else $error("device active does not mirror standby");
endmodule : tcsl_loader

// ==== rtl/tcsl_pkg.sv ====
// constants and types for the tuning word serial loader
package tcsl_pkg;
  localparam int unsigned WORD_W      = 8;
  localparam int unsigned TUNE_W      = 5;
  localparam int unsigned STBY_BIT    = 5;
  localparam int unsigned TUNE_MSB    = 4;
  localparam int unsigned TUNE_LSB    = 0;
  localparam int unsigned SYNC_DEPTH  = 3;
  localparam logic [7:0]  WORD_RESET  = 8'h00;
  localparam logic [4:0]  TUNE_MAX    = 5'h1F;
  // capacitance step index per state unit, linear in state
  localparam logic [5:0]  CAP_STEPS_PER_STATE = 6'h01;
  localparam int unsigned CLK_SYS_MHZ = 250;
  localparam int unsigned LINK_MAX_MHZ = 26;
  typedef logic [WORD_W-1:0] tcsl_word_type;
  typedef logic [TUNE_W-1:0] tcsl_tune_type;
endpackage : tcsl_pkg

// ==== rtl/tcsl_sync.sv ====
// three-stage synchroniser with agreement-based change detection
`timescale 1ns/100ps
module tcsl_sync
  import tcsl_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      level_q,
  output logic      rise,
  output logic      fall
);
  logic [SYNC_DEPTH-1:0] stage_q;
  logic                  stage_last;
  logic                  agree;

  // only the last two stages are compared, never the first
  assign stage_last = stage_q[SYNC_DEPTH-1];
  assign agree      = (stage_q[SYNC_DEPTH-2] == stage_last);

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[SYNC_DEPTH-2:0], pin_in};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= 1'b0;
    end else if (agree) begin
      level_q <= stage_last;
    end
  end

  assign rise = agree && stage_last && !level_q;
  assign fall = agree && !stage_last && level_q;
endmodule : tcsl_sync

// ==== testbench/tcsl_master.sv ====
// serial master model driving select, shift clock and data
`timescale 1ns/100ps
module tcsl_master (
  input  wire logic clk_sys,
  output logic      serial_select,
  output logic      shift_clk,
  output logic      shift_data_pin
);
  initial begin
    serial_select  = 1'b0;
    shift_clk      = 1'b0;
    shift_data_pin = 1'b0;
  end

  // 20 clocks a half period gives the 160 ns link clock
  task automatic send(input logic [15:0] w, input int n, input bit sel);
    @(posedge clk_sys);
    serial_select <= sel;
    repeat (10) @(posedge clk_sys);
    for (int i = n - 1; i >= 0; i--) begin
      shift_clk      <= 1'b0;
      shift_data_pin <= w[i];
      repeat (20) @(posedge clk_sys);
      shift_clk <= 1'b1;
      repeat (20) @(posedge clk_sys);
    end
    shift_clk      <= 1'b0;
    // released data must not keep showing the last bit
    shift_data_pin <= ~w[0];
    repeat (10) @(posedge clk_sys);
    serial_select <= 1'b0;
  endtask : send
endmodule : tcsl_master

// ==== testbench/tuning_word_serial_loader_tb_top.sv ====
// self-checking bench for the tuning word serial loader
`timescale 1ns/100ps
module tuning_word_serial_loader_tb_top;
  import tcsl_pkg::*;
  logic          clk_sys;
  logic          rst_b;
  logic          serial_select;
  logic          shift_clk;
  logic          shift_data_pin;
  tcsl_tune_type tuning_state;
  logic          standby_request;
  logic          device_active;
  logic [5:0]    cap_setting;
  logic          word_applied;
  logic          seen;
  int            miscompares = 0;
  int            checked = 0;

  tcsl_master u_master (.clk_sys(clk_sys), .serial_select(serial_select),
    .shift_clk(shift_clk), .shift_data_pin(shift_data_pin));
  tcsl_loader u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .serial_select(serial_select), .shift_clk(shift_clk),
    .shift_data_pin(shift_data_pin), .tuning_state(tuning_state),
    .standby_request(standby_request), .device_active(device_active),
    .cap_setting(cap_setting), .word_applied(word_applied));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  function automatic logic [12:0] want(input logic [7:0] w);
    return {w[5], ~w[5], w[4:0], 1'b0, w[4:0]};
  endfunction : want

  // sampled on falling edges so registered outputs have settled
  task automatic frame(input logic [15:0] w, input int n, input bit sel);
    int k;
    u_master.send(w, n, sel);
    k = 0;
    seen = 1'b0;
    while (word_applied !== 1'b1 && k < 20) begin
      @(negedge clk_sys);
      k++;
    end
    seen = (k < 20);
    if (sel && !seen) begin
      miscompares++;
      $display("Error at %0t: word never applied", $time);
      print_verdict();
    end
  endtask : frame

  task automatic t_reset();
    cmp({standby_request, device_active, tuning_state, cap_setting},
        want(8'h00));
  endtask : t_reset

  task automatic t_words();
    logic [7:0] tbl [5] = '{8'h1F, 8'h20, 8'h2B, 8'h01, 8'h01};
    foreach (tbl[i]) begin
      frame({8'h00, tbl[i]}, 8, 1'b1);
      cmp({standby_request, device_active, tuning_state, cap_setting},
          want(tbl[i]));
    end
  endtask : t_words

  task automatic t_length();
    frame(16'h0302, 10, 1'b1);
    cmp({standby_request, device_active, tuning_state, cap_setting},
        want(8'h02));
    frame(16'h000A, 4, 1'b1);
    cmp({standby_request, device_active, tuning_state, cap_setting},
        want(8'h2A));
  endtask : t_length

  task automatic t_ignored();
    frame(16'h003F, 8, 1'b0);
    cmp({12'h000, seen}, 13'h0000);
    cmp({standby_request, device_active, tuning_state, cap_setting},
        want(8'h2A));
  endtask : t_ignored

  task automatic t_midreset();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    cmp({standby_request, device_active, tuning_state, cap_setting},
        want(WORD_RESET));
    frame(16'h0035, 8, 1'b1);
    cmp({standby_request, device_active, tuning_state, cap_setting},
        want(8'h35));
  endtask : t_midreset

  initial begin
    rst_b = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_words();
    t_length();
    t_ignored();
    t_midreset();
    print_verdict();
  end
endmodule : tuning_word_serial_loader_tb_top
